// *** rtl/time_sync_pkg.sv ***
package time_sync_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIME_LO_OFS = 8'h04;
  localparam logic [7:0] TIME_HI_OFS = 8'h08;
  localparam logic [7:0] DIFF_OFS = 8'h0C;
  localparam logic [7:0] START_LO_OFS = 8'h10;
  localparam logic [7:0] START_HI_OFS = 8'h14;
  localparam logic [7:0] PERIOD_OFS = 8'h18;
  localparam logic [7:0] PLEN_OFS = 8'h1C;
  localparam logic [7:0] LATCH_LO_OFS = 8'h20;
  localparam logic [7:0] LATCH_HI_OFS = 8'h24;
  localparam logic [7:0] RX0_OFS = 8'h28;
  localparam logic [7:0] RX1_OFS = 8'h2C;
  localparam logic [7:0] CORE_RX_OFS = 8'h30;
  localparam logic [7:0] PEND_OFS = 8'h34;
  localparam logic [7:0] ENABLE_OFS = 8'h38;
  localparam logic [7:0] SYNC_STAT_OFS = 8'h3C;
  // Control fields
  localparam int CTRL_SYNC_EN = 0;
  localparam int CTRL_MII0 = 1;
  localparam int CTRL_MII1 = 2;
  // Cause bit positions
  localparam int EV_LATCH = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_RX0 = 2;
  localparam int EV_RX1 = 3;
  localparam int NUM_CAUSES = 4;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [31:0] PLEN_RST = 32'h0000_0001;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int TIME_CLK_MHZ = 100;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int TIME_CLK_NS = 1000 / TIME_CLK_MHZ;
  localparam int MII_CLK_MHZ = 25;
  localparam int MII_TICKS = TIME_CLK_MHZ / MII_CLK_MHZ;
  localparam logic [63:0] STEP_NS = 64'(TIME_CLK_NS);
  localparam int AVG_SHIFT = 3;
endpackage

// *** rtl/network_time_unit.sv ***
// Summary of operation
// [R1] All time logic runs on a 100 MHz grid, one tick per 10 ns.
// [R2] Times are in 1 ns units; pulse length is in 10 ns units.
// [R3] Readable system time changes only on a 10 ns tick.
// [R4] Port receive stamps at 10 ns grid, or 40 ns grid for MII ports.
// [R5] Local time follows the averaged difference, never stepping to it.
// [R6] Periodic pulse starts on the tick where local time reaches start time.
// [R7] Latch input is synchronised at the 10 ns rate, then time stamped.
// [R8] Interrupt is OR of pending causes enabled by the enable mask.
// [R9] Edge-triggered hosts re-read pending causes until empty before returning.
// [R10] Servicing access clears its cause; interrupt drops without acknowledge.
// [R11] Host should poll or use interrupts per source, not both.
// [R12] Local time advances 10 ns per tick, corrected by small adjustments.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module network_time_unit #(
  parameter int NPORTS = 2
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NPORTS-1:0] rx_frame_start,
  input wire logic input_timestamp_trigger,
  output logic periodic_output_pulse,
  output logic irq
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  // Bus slave
  logic ap_w;
  logic [7:0] ra_w;
  logic wr_r;
  logic [7:0] wa_r;
  logic [31:0] hrdata_r;
  logic [31:0] rmux_w;
  logic [31:0] rv_w [16];
  assign ap_w = hsel & htrans[1] & hready;
  assign ra_w = {haddr[7:2], 2'b00};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_r <= 1'b0;
      wa_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      wr_r <= ap_w & hwrite;
      wa_r <= ra_w;
      hrdata_r <= (ap_w & !hwrite) ? rmux_w : 32'h0000_0000;
    end
  end

  logic rd_w;
  logic wr_ctrl_w, wr_tlo_w, wr_thi_w, wr_diff_w, wr_slo_w, wr_shi_w;
  logic wr_per_w, wr_plen_w, wr_en_w;
  logic rd_pend_w, rd_latch_w, rd_sstat_w, rd_rx0_w, rd_rx1_w;
  assign rd_w = ap_w & !hwrite;
  assign wr_ctrl_w = wr_r & hit(wa_r, time_sync_pkg::CTRL_OFS);
  assign wr_tlo_w = wr_r & hit(wa_r, time_sync_pkg::TIME_LO_OFS);
  assign wr_thi_w = wr_r & hit(wa_r, time_sync_pkg::TIME_HI_OFS);
  assign wr_diff_w = wr_r & hit(wa_r, time_sync_pkg::DIFF_OFS);
  assign wr_slo_w = wr_r & hit(wa_r, time_sync_pkg::START_LO_OFS);
  assign wr_shi_w = wr_r & hit(wa_r, time_sync_pkg::START_HI_OFS);
  assign wr_per_w = wr_r & hit(wa_r, time_sync_pkg::PERIOD_OFS);
  assign wr_plen_w = wr_r & hit(wa_r, time_sync_pkg::PLEN_OFS);
  assign wr_en_w = wr_r & hit(wa_r, time_sync_pkg::ENABLE_OFS);
  assign rd_pend_w = rd_w & hit(ra_w, time_sync_pkg::PEND_OFS);
  assign rd_latch_w = rd_w & hit(ra_w, time_sync_pkg::LATCH_LO_OFS);
  assign rd_sstat_w = rd_w & hit(ra_w, time_sync_pkg::SYNC_STAT_OFS);
  assign rd_rx0_w = rd_w & hit(ra_w, time_sync_pkg::RX0_OFS);
  assign rd_rx1_w = rd_w & hit(ra_w, time_sync_pkg::RX1_OFS);

  // 10 ns tick from the 4 ns bus clock by phase accumulation
  logic [7:0] acc_r;
  logic [7:0] acc_sum_w;
  logic tick_w;
  assign acc_sum_w = acc_r + 8'(time_sync_pkg::CLK_NS);
  assign tick_w = acc_sum_w >= 8'(time_sync_pkg::TIME_CLK_NS); // R1
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_r <= 8'h00;
    else
      acc_r <= tick_w ? acc_sum_w - 8'(time_sync_pkg::TIME_CLK_NS) : acc_sum_w;
  end

  logic [1:0] quad_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      quad_r <= 2'h0;
    else if (tick_w)
      quad_r <= (quad_r == 2'(time_sync_pkg::MII_TICKS - 1)) ? 2'h0 : quad_r + 2'h1;
  end

  logic [31:0] ctrl_r;
  logic [63:0] sys_time_r;
  logic signed [31:0] filt_r;
  logic signed [31:0] corr_r;
  logic signed [31:0] filt_nxt;
  logic [63:0] step_w;
  assign filt_nxt = filt_r + ((signed'(hwdata) - filt_r) >>> time_sync_pkg::AVG_SHIFT); // R5
  assign step_w = (corr_r > 0) ? time_sync_pkg::STEP_NS - 64'h1 :
                  (corr_r < 0) ? time_sync_pkg::STEP_NS + 64'h1 :
                  time_sync_pkg::STEP_NS; // R12

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= time_sync_pkg::CTRL_RST;
    else if (wr_ctrl_w)
      ctrl_r <= hwdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sys_time_r <= 64'h0;
    else if (wr_tlo_w)
      sys_time_r <= {sys_time_r[63:32], hwdata};
    else if (wr_thi_w)
      sys_time_r <= {hwdata, sys_time_r[31:0]};
    else if (tick_w)
      sys_time_r <= sys_time_r + step_w; // R3 R12
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_r <= 32'sh0;
      corr_r <= 32'sh0;
    end
    else if (wr_diff_w)
    begin
      filt_r <= filt_nxt;
      corr_r <= filt_nxt; // R5
    end
    else if (tick_w && corr_r != 0)
      corr_r <= (corr_r > 0) ? corr_r - 32'sh1 : corr_r + 32'sh1;
  end

  // Receive time stamps per port
  logic [NPORTS-1:0] rx_s1_r, rx_s2_r, rx_s3_r, rx_req_r, rx_take_w;
  logic [31:0] rx_stamp_r [NPORTS];
  logic [31:0] core_rx_r;
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi++)
    begin : g_rx
      assign rx_take_w[gi] = tick_w & rx_req_r[gi] &
        (!ctrl_r[time_sync_pkg::CTRL_MII0 + gi] || quad_r == 2'h0); // R4
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          rx_s1_r[gi] <= 1'b0;
          rx_s2_r[gi] <= 1'b0;
          rx_s3_r[gi] <= 1'b0;
          rx_req_r[gi] <= 1'b0;
          rx_stamp_r[gi] <= 32'h0;
        end
        else
        begin
          rx_s1_r[gi] <= rx_frame_start[gi];
          rx_s2_r[gi] <= rx_s1_r[gi];
          rx_s3_r[gi] <= rx_s2_r[gi];
          rx_req_r[gi] <= (rx_req_r[gi] & !rx_take_w[gi]) | (rx_s2_r[gi] & !rx_s3_r[gi]);
          if (rx_take_w[gi])
            rx_stamp_r[gi] <= sys_time_r[31:0]; // R4
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      core_rx_r <= 32'h0;
    else if (rx_take_w[0])
      core_rx_r <= sys_time_r[31:0];
  end

  // Latch input: two flops, then sampled on the 10 ns tick
  logic lat_s1_r, lat_s2_r, lat_t_r, lat_tp_r, lat_ev_w;
  logic [63:0] latch_r;
  assign lat_ev_w = tick_w & lat_t_r & !lat_tp_r; // R7
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lat_s1_r <= 1'b0;
      lat_s2_r <= 1'b0;
      lat_t_r <= 1'b0;
      lat_tp_r <= 1'b0;
    end
    else
    begin
      lat_s1_r <= input_timestamp_trigger;
      lat_s2_r <= lat_s1_r;
      if (tick_w)
      begin
        lat_t_r <= lat_s2_r; // R7
        lat_tp_r <= lat_t_r;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      latch_r <= 64'h0;
    else if (lat_ev_w)
      latch_r <= sys_time_r; // R7
  end

  // Periodic output pulse
  logic [63:0] start_r;
  logic [31:0] period_r, plen_r, pcnt_r;
  logic shot_done_r, pulse_r, fire_w;
  assign fire_w = tick_w & ctrl_r[time_sync_pkg::CTRL_SYNC_EN] & !shot_done_r &
                  (sys_time_r >= start_r); // R6
  assign periodic_output_pulse = pulse_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_r <= 64'h0;
      shot_done_r <= 1'b0;
    end
    else if (wr_slo_w || wr_shi_w)
    begin
      start_r <= wr_slo_w ? {start_r[63:32], hwdata} : {hwdata, start_r[31:0]};
      shot_done_r <= 1'b0;
    end
    else if (fire_w)
    begin
      start_r <= start_r + {32'h0, period_r};
      shot_done_r <= (period_r == 32'h0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      period_r <= 32'h0;
      plen_r <= time_sync_pkg::PLEN_RST;
    end
    else
    begin
      if (wr_per_w)
        period_r <= hwdata;
      if (wr_plen_w)
        plen_r <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pulse_r <= 1'b0;
      pcnt_r <= 32'h0;
    end
    else if (fire_w)
    begin
      pulse_r <= (plen_r != 32'h0); // R6
      pcnt_r <= plen_r; // R2
    end
    else if (tick_w && pulse_r)
    begin
      pcnt_r <= pcnt_r - 32'h1; // R2
      pulse_r <= (pcnt_r != 32'h1);
    end
  end

  // Pending causes, enable mask and interrupt
  localparam int NC = time_sync_pkg::NUM_CAUSES;
  logic [NC-1:0] pend_r, en_r, ev_w, clr_w;
  assign ev_w = {rx_take_w[1], rx_take_w[0], fire_w, lat_ev_w};
  assign clr_w = {NC{rd_pend_w}} |
                 {rd_rx1_w, rd_rx0_w, rd_sstat_w, rd_latch_w}; // R10
  assign irq = |(pend_r & en_r); // R8

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_r <= '0;
      en_r <= time_sync_pkg::ENABLE_RST;
    end
    else
    begin
      pend_r <= (pend_r & ~clr_w) | ev_w; // R10
      if (wr_en_w)
        en_r <= hwdata[NC-1:0];
    end
  end

  always_comb
  begin
    for (int i = 0; i < 16; i++)
      rv_w[i] = 32'h0;
    rv_w[time_sync_pkg::CTRL_OFS[5:2]] = ctrl_r;
    rv_w[time_sync_pkg::TIME_LO_OFS[5:2]] = sys_time_r[31:0]; // R3
    rv_w[time_sync_pkg::TIME_HI_OFS[5:2]] = sys_time_r[63:32];
    rv_w[time_sync_pkg::DIFF_OFS[5:2]] = filt_r;
    rv_w[time_sync_pkg::START_LO_OFS[5:2]] = start_r[31:0];
    rv_w[time_sync_pkg::START_HI_OFS[5:2]] = start_r[63:32];
    rv_w[time_sync_pkg::PERIOD_OFS[5:2]] = period_r;
    rv_w[time_sync_pkg::PLEN_OFS[5:2]] = plen_r;
    rv_w[time_sync_pkg::LATCH_LO_OFS[5:2]] = latch_r[31:0];
    rv_w[time_sync_pkg::LATCH_HI_OFS[5:2]] = latch_r[63:32];
    rv_w[time_sync_pkg::RX0_OFS[5:2]] = rx_stamp_r[0];
    rv_w[time_sync_pkg::RX1_OFS[5:2]] = rx_stamp_r[1];
    rv_w[time_sync_pkg::CORE_RX_OFS[5:2]] = core_rx_r;
    rv_w[time_sync_pkg::PEND_OFS[5:2]] = {28'h0, pend_r};
    rv_w[time_sync_pkg::ENABLE_OFS[5:2]] = {28'h0, en_r};
    rv_w[time_sync_pkg::SYNC_STAT_OFS[5:2]] = {31'h0, pulse_r};
  end
  assign rmux_w = (haddr[7:6] == 2'b00) ? rv_w[haddr[5:2]] : 32'h0;

  tick_gap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    tick_w |=> !tick_w) else $error("ticks closer than 10 ns");
  tick_late_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    hresetn && !tick_w ##1 !tick_w |=> tick_w) else $error("tick missing");
  time_grid_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    !tick_w && !wr_tlo_w && !wr_thi_w |=> $stable(sys_time_r))
    else $error("time changed off tick");
  time_step_a: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    tick_w && corr_r == 0 && !wr_tlo_w && !wr_thi_w |=> sys_time_r == $past(sys_time_r) + 64'hA)
    else $error("time step not 10 ns");
  avg_load_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    wr_diff_w |=> corr_r == filt_r && ($past(filt_r) <= signed'($past(hwdata)) ?
      filt_r >= $past(filt_r) && filt_r <= signed'($past(hwdata)) :
      filt_r <= $past(filt_r) && filt_r >= signed'($past(hwdata))))
    else $error("difference not averaged");
  mii_grid_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    ctrl_r[time_sync_pkg::CTRL_MII0] && rx_take_w[0] ||
    ctrl_r[time_sync_pkg::CTRL_MII1] && rx_take_w[1] |-> quad_r == 2'h0)
    else $error("mii stamp off 40 ns grid");
  pulse_start_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    fire_w && plen_r != 0 |=> pulse_r && pcnt_r == $past(plen_r)) else $error("pulse not started");
  pulse_len_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    pulse_r && tick_w && pcnt_r == 32'h1 && !fire_w |=> !pulse_r) else $error("pulse length wrong");
  latch_stamp_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    lat_ev_w |=> latch_r == $past(sys_time_r) && pend_r[time_sync_pkg::EV_LATCH])
    else $error("latch not stamped");
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    irq && !rd_w && !wr_en_w |=> irq) else $error("interrupt dropped unserviced");
  pend_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    rd_pend_w && ev_w == '0 |=> pend_r == '0 && !irq) else $error("pending not cleared");
endmodule
`default_nettype wire

// *** testbench/net_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module net_master_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] fire,
  output logic [1:0] rx_frame_start,
  output logic input_timestamp_trigger
);
  logic [2:0] pins_r;
  logic [2:0] cnt_r;
  // A requested edge is held for seven clocks so the far side sees it once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pins_r <= 3'h0;
      cnt_r <= 3'h0;
    end
    else if (fire != 3'h0)
    begin
      pins_r <= fire;
      cnt_r <= 3'h6;
    end
    else if (cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
    else
      pins_r <= 3'h0;
  end
  assign {input_timestamp_trigger, rx_frame_start} = pins_r;
endmodule
`default_nettype wire

// *** testbench/network_time_unit_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module network_time_unit_tb_top;
  logic hclk, hresetn, hsel, hwrite, rdy_s, hreadyout, hresp;
  logic input_timestamp_trigger, periodic_output_pulse, irq;
  logic [31:0] haddr, hwdata, hrdata, rd_s, got, a, b, c;
  logic [1:0] htrans, rx_frame_start;
  logic [2:0] fire;
  int n_mismatch, n_compared, n, k;
  logic [7:0] ra [0:5] = '{8'h00, 8'h38, 8'h1C, 8'h34, 8'h18, 8'h40};
  logic [31:0] rv [0:5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};

  network_time_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_frame_start(rx_frame_start),
    .input_timestamp_trigger(input_timestamp_trigger),
    .periodic_output_pulse(periodic_output_pulse), .irq(irq));
  net_master_model i_peer (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .rx_frame_start(rx_frame_start), .input_timestamp_trigger(input_timestamp_trigger));

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    rd_s <= hrdata;
    rdy_s <= hreadyout;
  end

  task automatic edge1;
    @(posedge hclk);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    edge1();
    while (rdy_s !== 1'b1) edge1();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge1();
    while (rdy_s !== 1'b1) edge1();
    got = rd_s;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(got, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic pin(input logic [2:0] v);
    fire <= v;
    @(posedge hclk);
    fire <= 3'h0;
  endtask
  task automatic wait_irq;
    k = 0;
    while (irq !== 1'b1 && k < 60)
    begin
      edge1();
      k++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    fire = 3'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
    chk({31'h0, irq}, 32'h0);
    $display("end reset values");
    // Two reads exactly 50 clocks apart span 20 time ticks
    bus(1'b0, time_sync_pkg::TIME_LO_OFS, 32'h0);
    a = got;
    repeat (48) @(posedge hclk);
    bus(1'b0, time_sync_pkg::TIME_LO_OFS, 32'h0);
    chk(got - a, 32'hC8);
    chk(got % 32'hA, 32'h0);
    $display("end time advance");
    // Port 1 as MII, port 0 as low voltage bus link
    bus(1'b1, time_sync_pkg::CTRL_OFS, 32'h4);
    bus(1'b1, time_sync_pkg::ENABLE_OFS, 32'hC);
    pin(3'h1);
    wait_irq();
    bus(1'b0, time_sync_pkg::RX0_OFS, 32'h0);
    c = got;
    chk(c % 32'hA, 32'h0);
    rdc(time_sync_pkg::CORE_RX_OFS, c);
    pin(3'h2);
    wait_irq();
    bus(1'b0, time_sync_pkg::RX1_OFS, 32'h0);
    a = got;
    repeat (37) @(posedge hclk);
    pin(3'h2);
    wait_irq();
    bus(1'b0, time_sync_pkg::RX1_OFS, 32'h0);
    b = got;
    chk((b - a) % 32'h28, 32'h0);
    chk({31'h0, b != a}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("end receive stamps");
    // Both ports on the MII grid stamp one frame start on the same tick
    bus(1'b1, time_sync_pkg::CTRL_OFS, 32'h6);
    pin(3'h3);
    wait_irq();
    bus(1'b0, time_sync_pkg::RX0_OFS, 32'h0);
    c = got;
    chk((c - b) % 32'h28, 32'h0);
    rdc(time_sync_pkg::RX1_OFS, c);
    chk({31'h0, irq}, 32'h0);
    $display("end mii grid");
    // Masked cause is polled only, then unmasked and serviced by interrupt
    bus(1'b1, time_sync_pkg::ENABLE_OFS, 32'h0);
    pin(3'h4);
    repeat (30) edge1();
    chk({31'h0, irq}, 32'h0);
    rdc(time_sync_pkg::PEND_OFS, 32'h1);
    rdc(time_sync_pkg::PEND_OFS, 32'h0);
    bus(1'b1, time_sync_pkg::ENABLE_OFS, 32'h1);
    pin(3'h4);
    wait_irq();
    bus(1'b0, time_sync_pkg::LATCH_LO_OFS, 32'h0);
    chk(got % 32'hA, 32'h0);
    chk({31'h0, irq}, 32'h0);
    k = 0;
    do
    begin
      bus(1'b0, time_sync_pkg::PEND_OFS, 32'h0);
      k++;
    end
    while (got !== 32'h0 && k < 8);
    chk(got, 32'h0);
    $display("end interrupt");
    bus(1'b1, time_sync_pkg::PLEN_OFS, 32'h4);
    bus(1'b1, time_sync_pkg::PERIOD_OFS, 32'h0);
    bus(1'b1, time_sync_pkg::ENABLE_OFS, 32'h2);
    bus(1'b1, time_sync_pkg::START_HI_OFS, 32'h0);
    bus(1'b0, time_sync_pkg::TIME_LO_OFS, 32'h0);
    bus(1'b1, time_sync_pkg::START_LO_OFS, got + 32'h190);
    bus(1'b1, time_sync_pkg::CTRL_OFS, 32'h1);
    n = 5;
    while (periodic_output_pulse !== 1'b1 && n < 200)
    begin
      edge1();
      n++;
    end
    chk({31'h0, n >= 99 && n <= 104}, 32'h1);
    n = 0;
    while (periodic_output_pulse === 1'b1 && n < 40)
    begin
      edge1();
      n++;
    end
    chk({31'h0, n >= 9 && n <= 11}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(time_sync_pkg::SYNC_STAT_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("end periodic pulse");
    bus(1'b1, time_sync_pkg::DIFF_OFS, 32'h50);
    rdc(time_sync_pkg::DIFF_OFS, 32'hA);
    bus(1'b1, time_sync_pkg::DIFF_OFS, 32'h50);
    rdc(time_sync_pkg::DIFF_OFS, 32'h12);
    $display("end averaging");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(time_sync_pkg::DIFF_OFS, 32'h0);
    rdc(time_sync_pkg::ENABLE_OFS, 32'h0);
    chk({31'h0, irq | periodic_output_pulse}, 32'h0);
    $display("end mid-run reset");
    close_out();
  end
endmodule
`default_nettype wire
